// ### design/bsepw_host.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
// Behaviour
// - Write: reset, address, 1-32 bytes, start.
// - Address sent as 16 bits, MSB first.
// - Data sent as whole bytes, no reads.
// - Start command is read, write one, read.
// - Control register lives at address FFFFh.
// - Exactly one byte written to control register.
// - Writing one after a read ends it.
// - Reset sequence is read, write zero, read.
module bsepw_host (
   mclk,
   rst,
   sw_addr,
   sw_wdata,
   sw_wr,
   sw_rd,
   sw_rdata,
   ce_n,
   oe_n,
   we_n,
   io_out,
   io_oe,
   io_in
);
   input  wire logic        mclk;
   input  wire logic        rst;
   input  wire logic [1:0]  sw_addr;
   input  wire logic [31:0] sw_wdata;
   input  wire logic        sw_wr;
   input  wire logic        sw_rd;
   output logic      [31:0] sw_rdata;
   output logic             ce_n;
   output logic             oe_n;
   output logic             we_n;
   output logic             io_out;
   output logic             io_oe;
   input  wire logic        io_in;

   typedef enum logic [2:0] {
      BSEPW_IDLE  = 3'h0,
      BSEPW_RST   = 3'h1,
      BSEPW_ADDR  = 3'h3,
      BSEPW_DATA  = 3'h2,
      BSEPW_START = 3'h6,
      BSEPW_POLL  = 3'h7,
      BSEPW_QUIT  = 3'h5
   } bsepw_state_type;

   typedef struct packed {
      bsepw_state_type st;
      logic [15:0]     addr;
      logic [5:0]      nbytes;
      logic [1:0]      step;
      logic [4:0]      byte_i;
      logic [2:0]      bit_i;
      logic [3:0]      abit_i;
      logic            issued;
      logic            err;
      logic            status;
      logic [31:0]     rdata;
      logic [7:0][31:0] page;
   } bsepw_reg_type;

   bsepw_reg_type r_q;
   bsepw_reg_type r_d;
   logic          pc_start;
   logic          pc_write;
   logic          pc_bit;
   logic          pc_done;
   logic          pc_rbit;
   logic          pc_busy;
   logic [7:0]    cur_byte;
   logic          is_ctrl;
   logic          busy_all;

   assign busy_all = (r_q.st != BSEPW_IDLE);
   assign is_ctrl  = (r_q.addr == bsepw_pkg::ADDR_CTRL_REG);
   assign cur_byte = r_q.page[r_q.byte_i[4:2]][r_q.byte_i[1:0]*8 +: 8];

   always_comb begin
      r_d      = r_q;
      pc_start = 1'b0;
      pc_write = 1'b0;
      pc_bit   = 1'b0;
      // Software port writes; ignored while a sequence runs so the pins stay sane.
      if (sw_wr && !busy_all) begin
         unique case (sw_addr)
            bsepw_pkg::SW_ADDR_LO: begin
               r_d.addr = sw_wdata[15:0];
            end
            bsepw_pkg::SW_ADDR_HI: begin
               r_d.page[sw_wdata[15:13]] = r_q.page[sw_wdata[15:13]];
            end
            bsepw_pkg::SW_DATA: begin
               r_d.page[sw_wdata[2:0]] = sw_wdata[31:0];
            end
            bsepw_pkg::SW_CTRL: begin
               r_d.err    = 1'b0;
               r_d.step   = 2'h0;
               r_d.issued = 1'b0;
               unique case (sw_wdata[1:0])
                  bsepw_pkg::CTRL_GO_PAGE: begin
                     r_d.nbytes = (sw_wdata[13:8] == 6'h0 ||
                        sw_wdata[13:8] > bsepw_pkg::PAGE_BYTES_W)
                        ? 6'h1 : sw_wdata[13:8];
                     // Flag a byte count that had to be clamped to one.
                     r_d.err = (sw_wdata[13:8] == 6'h0 ||
                        sw_wdata[13:8] > bsepw_pkg::PAGE_BYTES_W);
                     // One byte only for the control register.
                     if (is_ctrl) begin
                        r_d.nbytes = 6'h1;
                        r_d.page[0][7:0] = r_q.page[0][7:0]
                           & bsepw_pkg::CTRL_USED_MASK;
                     end
                     r_d.st     = BSEPW_RST;
                     r_d.byte_i = 5'h0;
                     r_d.bit_i  = 3'h7;
                     r_d.abit_i = 4'hF;
                     r_d.status = 1'b0;
                  end
                  bsepw_pkg::CTRL_GO_POLL: r_d.st = BSEPW_POLL;
                  bsepw_pkg::CTRL_GO_RST: begin
                     r_d.st     = BSEPW_RST;
                     r_d.nbytes = 6'h0;
                  end
                  bsepw_pkg::CTRL_GO_IDLE: r_d.st = BSEPW_QUIT;
               endcase
            end
         endcase
      end
      if (sw_rd) begin
         unique case (sw_addr)
            bsepw_pkg::SW_ADDR_LO: r_d.rdata = {16'h0000, r_q.addr};
            bsepw_pkg::SW_CTRL: r_d.rdata = {28'h0000000, r_q.err,
                                             r_q.status, 1'b0, busy_all};
            bsepw_pkg::SW_DATA: r_d.rdata = r_q.page[0];
            bsepw_pkg::SW_ADDR_HI: r_d.rdata = {26'h0000000, r_q.nbytes};
         endcase
      end else begin
         r_d.rdata = 32'h00000000;
      end

      // Launch the next pin cycle once the previous one has finished.
      if (busy_all && !r_q.issued && !pc_busy) begin
         pc_start = 1'b1;
         r_d.issued = 1'b1;
      end
      unique case (r_q.st)
         BSEPW_IDLE: ;
         BSEPW_RST: begin
            // Read, write zero, read; also breaks off any open sequence.
            pc_write = (r_q.step == 2'h1);
            pc_bit   = 1'b0;
         end
         BSEPW_ADDR: begin
            pc_write = 1'b1;
            pc_bit   = r_q.addr[r_q.abit_i];
         end
         BSEPW_DATA: begin
            // No reads interleave, so the load stays valid.
            pc_write = 1'b1;
            pc_bit   = cur_byte[r_q.bit_i];
         end
         BSEPW_START: begin
            pc_write = (r_q.step == 2'h1);
            pc_bit   = 1'b1;
         end
         BSEPW_POLL: pc_write = 1'b0;
         BSEPW_QUIT: begin
            // A lone write of one ends a read and parks the device.
            pc_write = 1'b1;
            pc_bit   = 1'b1;
         end
         default: r_d.st = BSEPW_IDLE;
      endcase

      if (pc_done) begin
         r_d.issued = 1'b0;
         unique case (r_q.st)
            BSEPW_RST: begin
               r_d.step = r_q.step + 2'h1;
               if (r_q.step == 2'h2) begin
                  r_d.step = 2'h0;
                  r_d.st = (r_q.nbytes == 6'h0) ? BSEPW_IDLE : BSEPW_ADDR;
               end
            end
            BSEPW_ADDR: begin
               r_d.abit_i = r_q.abit_i - 4'h1;
               if (r_q.abit_i == 4'h0) r_d.st = BSEPW_DATA;
            end
            BSEPW_DATA: begin
               r_d.bit_i = r_q.bit_i - 3'h1;
               if (r_q.bit_i == 3'h0) begin
                  r_d.byte_i = r_q.byte_i + 5'h1;
                  // Host never exceeds one page, so no wrap overwrite.
                  if ({1'b0, r_q.byte_i} + 6'h1 == r_q.nbytes)
                     r_d.st = BSEPW_START;
               end
            end
            BSEPW_START: begin
               r_d.step = r_q.step + 2'h1;
               if (r_q.step == 2'h2) begin
                  r_d.step = 2'h0;
                  r_d.st   = BSEPW_POLL;
               end
            end
            BSEPW_POLL: begin
               // Low while programming, high when done.
               r_d.status = pc_rbit;
               r_d.st     = BSEPW_IDLE;
            end
            BSEPW_QUIT: r_d.st = BSEPW_IDLE;
            default: r_d.st = BSEPW_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign sw_rdata = r_q.rdata;

   bsepw_pin_cycle u_cycle (
      .mclk     (mclk),
      .rst      (rst),
      .start    (pc_start),
      .is_write (pc_write),
      .wbit     (pc_bit),
      .done     (pc_done),
      .rbit     (pc_rbit),
      .busy     (pc_busy),
      .ce_n     (ce_n),
      .oe_n     (oe_n),
      .we_n     (we_n),
      .io_out   (io_out),
      .io_oe    (io_oe),
      .io_in    (io_in)
   );
endmodule // bsepw_host

// ### design/bsepw_pin_cycle.sv
`timescale 1ns/10ps
// One bus cycle on the device pins: a read or a one-bit write.
module bsepw_pin_cycle (
   mclk,
   rst,
   start,
   is_write,
   wbit,
   done,
   rbit,
   busy,
   ce_n,
   oe_n,
   we_n,
   io_out,
   io_oe,
   io_in
);
   input  wire logic mclk;
   input  wire logic rst;
   input  wire logic start;
   input  wire logic is_write;
   input  wire logic wbit;
   output logic      done;
   output logic      rbit;
   output logic      busy;
   output logic      ce_n;
   output logic      oe_n;
   output logic      we_n;
   output logic      io_out;
   output logic      io_oe;
   input  wire logic io_in;

   typedef enum logic [1:0] {
      BSEPW_PC_IDLE  = 2'h0,
      BSEPW_PC_SETUP = 2'h1,
      BSEPW_PC_STRB  = 2'h3,
      BSEPW_PC_HOLD  = 2'h2
   } bsepw_pc_state_type;

   typedef struct packed {
      bsepw_pc_state_type st;
      logic [3:0]         cnt;
      logic               wr;
      logic               bitv;
      logic               rbit;
      logic               done;
      logic               ce_n;
      logic               oe_n;
      logic               we_n;
   } bsepw_pc_reg_type;

   bsepw_pc_reg_type r_q;
   bsepw_pc_reg_type r_d;

   always_comb begin
      r_d      = r_q;
      r_d.done = 1'b0;
      unique case (r_q.st)
         BSEPW_PC_IDLE: begin
            if (start) begin
               r_d.st   = BSEPW_PC_SETUP;
               r_d.wr   = is_write;
               r_d.bitv = wbit;
               r_d.cnt  = bsepw_pkg::SETUP_CYC;
               r_d.ce_n = 1'b0;
            end
         end
         BSEPW_PC_SETUP: begin
            r_d.cnt = r_q.cnt - 4'h1;
            if (r_q.cnt == 4'h1) begin
               r_d.st  = BSEPW_PC_STRB;
               r_d.cnt = bsepw_pkg::STROBE_CYC;
               // WE and OE are never low together while CE is low.
               r_d.we_n = ~r_q.wr;
               r_d.oe_n = r_q.wr;
            end
         end
         BSEPW_PC_STRB: begin
            r_d.cnt = r_q.cnt - 4'h1;
            if (r_q.cnt == 4'h1) begin
               // Sample before OE rises; WE rising latches the bit.
               r_d.rbit = io_in;
               r_d.we_n = 1'b1;
               r_d.oe_n = 1'b1;
               r_d.st   = BSEPW_PC_HOLD;
               r_d.cnt  = bsepw_pkg::HOLD_CYC;
            end
         end
         BSEPW_PC_HOLD: begin
            r_d.cnt  = r_q.cnt - 4'h1;
            r_d.ce_n = 1'b1;
            if (r_q.cnt == 4'h1) begin
               r_d.st   = BSEPW_PC_IDLE;
               r_d.done = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r_q <= '{st: BSEPW_PC_IDLE, cnt: 4'h0, wr: 1'b0, bitv: 1'b0,
                  rbit: 1'b0, done: 1'b0, ce_n: 1'b1, oe_n: 1'b1,
                  we_n: 1'b1};
      end else begin
         r_q <= r_d;
      end
   end

   assign done   = r_q.done;
   assign rbit   = r_q.rbit;
   assign busy   = (r_q.st != BSEPW_PC_IDLE);
   assign ce_n   = r_q.ce_n;
   assign oe_n   = r_q.oe_n;
   assign we_n   = r_q.we_n;
   // Drive data through the whole write cycle, held past WE/CE rise.
   assign io_out = r_q.bitv;
   assign io_oe  = r_q.wr & (r_q.st != BSEPW_PC_IDLE);
endmodule // bsepw_pin_cycle

// ### design/bsepw_pkg.sv
package bsepw_pkg;
   localparam logic [15:0] ADDR_CTRL_REG  = 16'hFFFF;
   localparam int          ADDR_BITS      = 16;
   localparam int          BYTE_BITS      = 8;
   localparam int          PAGE_BYTES     = 32;
   localparam logic [5:0]  PAGE_BYTES_W   = 6'h20;
   localparam int          PWP_BIT        = 7;
   localparam int          BG_HI_BIT      = 3;
   localparam int          BG_LO_BIT      = 2;
   localparam logic [7:0]  CTRL_USED_MASK = 8'h8C;
   localparam logic [1:0]  SW_ADDR_LO     = 2'h0;
   localparam logic [1:0]  SW_ADDR_HI     = 2'h1;
   localparam logic [1:0]  SW_CTRL        = 2'h2;
   localparam logic [1:0]  SW_DATA        = 2'h3;
   localparam logic [1:0]  CTRL_GO_PAGE   = 2'h0;
   localparam logic [1:0]  CTRL_GO_POLL   = 2'h1;
   localparam logic [1:0]  CTRL_GO_RST    = 2'h2;
   localparam logic [1:0]  CTRL_GO_IDLE   = 2'h3;
   localparam int          BUF_IDX_W      = 5;
   // Strobe phases of one pin cycle, each in ns, rounded up to mclk cycles.
   localparam int          T_SETUP_NS     = 20;
   localparam int          T_STROBE_NS    = 40;
   localparam int          T_HOLD_NS      = 20;
   localparam int          MCLK_NS        = 4;
   localparam logic [3:0]  SETUP_CYC = 4'((T_SETUP_NS + MCLK_NS - 1) / MCLK_NS);
   localparam logic [3:0]  STROBE_CYC = 4'((T_STROBE_NS + MCLK_NS - 1) / MCLK_NS);
   localparam logic [3:0]  HOLD_CYC = 4'((T_HOLD_NS + MCLK_NS - 1) / MCLK_NS);
   localparam logic [2:0]  OP_RD          = 3'h0;
   localparam logic [2:0]  OP_WR0         = 3'h1;
   localparam logic [2:0]  OP_WR1         = 3'h2;
   localparam logic [2:0]  OP_WRB         = 3'h3;
endpackage

// ### tb/bsepw_dev_model.sv
`timescale 1ns/10ps
module bsepw_dev_model #(parameter int ARR_W = 13) (
   input  wire logic mclk,
   input  wire logic ce_n,
   input  wire logic oe_n,
   input  wire logic we_n,
   input  wire logic io_out,
   input  wire logic io_oe,
   input  wire logic wp_n,
   output logic      io_in
);
   logic [1:0]  h1 = 2'h0, h2 = 2'h0;
   logic [15:0] addr_q = 16'h0000;
   logic [7:0]  sr, byte0, ctrl_q = 8'h00;
   logic        wel = 1'b0, load = 1'b0, brk = 1'b0, dv_q = 1'b1;
   logic        hwp, grd, dv;
   int          nb = 0, progs = 0, rsts = 0, busy = 0;
   assign hwp = !wp_n && ctrl_q[7];
   assign grd = (ctrl_q[3:2] == 2'h3) || (ctrl_q[3:2] == 2'h2 &&
      addr_q[ARR_W-1]) || (ctrl_q[3:2] == 2'h1 && &addr_q[ARR_W-1 -: 2]);
   assign dv = (busy != 0) ? 1'b0 : 1'b1;
   // A released line shows the inverse of the last level read, never a hold.
   assign io_in = io_oe ? io_out : (!ce_n && !oe_n) ? dv : !dv_q;
   always @(posedge mclk) begin
      if (busy != 0) busy <= busy - 1;
   end
   always @(negedge wp_n) wel = 1'b0;
   task automatic step(input logic [1:0] c);
      if (h2 == 2'h0 && h1 == 2'h1 && c == 2'h0) begin
         rsts++;
         if (busy == 0) begin
            wel = wp_n;
            load = 1'b1;
            brk = 1'b0;
            nb = 0;
         end
      end else if (h2 == 2'h0 && h1 == 2'h2 && c == 2'h0 && load) begin
         if (wel && nb >= 24 && nb % 8 == 0 &&
             !(addr_q == 16'hFFFF && nb != 24) &&
             !((addr_q == 16'hFFFF) ? hwp : grd)) begin
            progs++;
            busy = 200;
            if (addr_q == 16'hFFFF) ctrl_q = byte0 & 8'h8C;
         end
         wel = 1'b0;
         load = 1'b0;
      end else if (c == 2'h0) brk = 1'b1;
      else if (load && !brk) begin
         if (nb < 16) addr_q = {addr_q[14:0], c[1]};
         else sr = {sr[6:0], c[1]};
         if ((nb - 16) % 256 == 7) byte0 = sr;
         nb++;
      end
      h2 = h1;
      h1 = c;
   endtask
   always @(posedge we_n) if (!ce_n) step({io_in, !io_in});
   always @(posedge oe_n) if (!ce_n) begin
      dv_q = dv;
      step(2'h0);
   end
endmodule // bsepw_dev_model

// ### tb/bsepw_host_properties.sv
`timescale 1ns/10ps
module bsepw_host_checker (
   input wire logic mclk,
   input wire logic rst,
   input wire logic sw_rd,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic io_out,
   input wire logic io_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_strobe_excl: assert property (we_n || oe_n)
      else $error("both strobes low");
   a_ce_frames: assert property ((!we_n || !oe_n) |-> !ce_n)
      else $error("strobe without select");
   a_read_floats: assert property (!oe_n |-> !io_oe)
      else $error("host drives during read");
   a_write_drives: assert property (!we_n |-> io_oe)
      else $error("write without drive");
   a_bit_steady: assert property (!we_n && !$past(we_n) |-> $stable(io_out))
      else $error("bit moved under strobe");
   a_setup_gap: assert property ($fell(ce_n) |-> (we_n && oe_n)[*4])
      else $error("strobe too soon");
   a_we_width: assert property
      ($fell(we_n) |-> (!we_n)[*8] ##1 (!we_n)[*2] ##1 we_n)
      else $error("write strobe width");
   a_oe_width: assert property
      ($fell(oe_n) |-> (!oe_n)[*8] ##1 (!oe_n)[*2] ##1 oe_n)
      else $error("read strobe width");
   a_hold_gap: assert property
      ($rose(ce_n) |-> $past(we_n) && $past(oe_n))
      else $error("select dropped early");
   cover property ($fell(we_n));
   cover property ($fell(oe_n));
   cover property (sw_rd);
endmodule // bsepw_host_checker

bind bsepw_host bsepw_host_checker u_chk (.mclk(mclk), .rst(rst),
   .sw_rd(sw_rd), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
   .io_out(io_out), .io_oe(io_oe));

// ### tb/bsepw_host_tb_top.sv
`timescale 1ns/10ps
module bsepw_host_tb_top;
   logic        mclk, rst, sw_wr, sw_rd, wp_n, ce_n, oe_n, we_n;
   logic        io_out, io_oe, io_in;
   logic [1:0]  sw_addr;
   logic [31:0] sw_wdata, sw_rdata, d;
   int          num_errors = 0, compares = 0, p;
   bsepw_host uut (.mclk(mclk), .rst(rst), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
      .sw_rdata(sw_rdata), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .io_out(io_out), .io_oe(io_oe), .io_in(io_in));
   bsepw_dev_model m (.mclk(mclk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
      .io_out(io_out), .io_oe(io_oe), .wp_n(wp_n), .io_in(io_in));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h vs %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [1:0] a, input logic [31:0] v);
      @(posedge mclk);
      sw_wr <= 1'b1;
      sw_addr <= a;
      sw_wdata <= v;
      @(posedge mclk);
      sw_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, output logic [31:0] v);
      @(posedge mclk);
      sw_rd <= 1'b1;
      sw_addr <= a;
      @(posedge mclk);
      sw_rd <= 1'b0;
      #1 v = sw_rdata;
   endtask
   task automatic wait_idle;
      int n;
      n = 0;
      d = 32'h1;
      while (d[0] !== 1'b0 && n < 1000) begin
         rd(2'h2, d);
         n++;
      end
      chk(d & 32'h1, 32'h0);
   endtask
   task automatic t_pages;
      logic [5:0] nbyt [4] = '{6'h01, 6'h00, 6'h21, 6'h04};
      int         bits [4] = '{24, 24, 24, 48};
      logic [31:0] errs [4] = '{32'h0, 32'h8, 32'h8, 32'h0};
      for (int i = 0; i < 4; i++) begin
         p = m.progs;
         wr(2'h0, 32'h0000_0040);
         rd(2'h0, d);
         chk(d & 32'hFFFF, 32'h0040);
         wr(2'h3, 32'h5A5A_5AA8);
         wr(2'h2, {18'h0, nbyt[i], 8'h00});
         rd(2'h2, d);
         chk(d & 32'h1, 32'h1);
         chk(d & 32'h8, errs[i]);
         wait_idle();
         chk(32'(m.addr_q), 32'h0040);
         chk(m.nb, bits[i]);
         chk(32'(m.byte0), 32'hA8);
         chk(m.progs, p + 1);
         rd(2'h2, d);
         chk(d & 32'h4, 32'h0);
         repeat (250) @(posedge mclk);
      end
      wr(2'h2, 32'h1);
      wait_idle();
      rd(2'h2, d);
      chk(d & 32'h4, 32'h4);
   endtask
   task automatic t_ctrl;
      wr(2'h0, 32'h0000_FFFF);
      wr(2'h3, 32'h0000_00F8);
      wr(2'h2, 32'h0000_0500);
      wait_idle();
      chk(m.nb, 24);
      chk(32'(m.byte0), 32'h88);
      chk(32'(m.ctrl_q), 32'h88);
      repeat (250) @(posedge mclk);
   endtask
   task automatic t_cmds;
      p = m.rsts;
      wr(2'h2, 32'h2);
      wait_idle();
      chk(m.rsts, p + 1);
      chk(32'(m.wel), 32'h1);
      wr(2'h2, 32'h3);
      wait_idle();
      chk(32'(m.h1), 32'h2);
   endtask
   task automatic page_at(input logic [15:0] a, input logic [5:0] n);
      wr(2'h0, {16'h0000, a});
      wr(2'h2, {18'h0, n, 8'h00});
      wait_idle();
   endtask
   // Relies on the control byte left by t_ctrl: pin enable, upper half.
   task automatic t_guard;
      p = m.progs;
      page_at(16'h0040, 6'h01);
      chk(m.progs, p + 1);
      repeat (250) @(posedge mclk);
      page_at(16'h1040, 6'h01);
      chk(m.progs, p + 1);
      chk(32'(m.wel), 32'h0);
      @(posedge mclk);
      wp_n <= 1'b0;
      page_at(16'h0040, 6'h01);
      chk(m.progs, p + 1);
      chk(32'(m.wel), 32'h0);
   endtask
   task automatic close_out;
      if (num_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #80000;
      num_errors++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      sw_wr = 1'b0;
      sw_rd = 1'b0;
      sw_addr = 2'h0;
      sw_wdata = 32'h0;
      wp_n = 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      chk(32'(ce_n), 32'h1);
      t_pages();
      t_ctrl();
      t_cmds();
      t_guard();
      close_out();
   end
endmodule // bsepw_host_tb_top
